// File: src/wdog_pkg.sv
/*
 * Constants shared by the watchdog and its tick prescaler.
 * Assumes a single 100 MHz system clock; tick sources arrive as enable pulses.
 */
package wdog_pkg;
	localparam int CNT_W = 24;
	localparam logic [7:0] FEED_KEY_FIRST = 8'hAA;
	localparam logic [7:0] FEED_KEY_SECOND = 8'h55;
	localparam logic [23:0] CONST_MIN = 24'h0000FF;
	localparam logic [23:0] CONST_RESET = 24'h0000FF;
	localparam logic [23:0] COUNT_RESET = 24'hFFFFFF;
	localparam logic [1:0] PRESCALE_LAST = 2'h3;
	localparam logic [1:0] SEL_RESET = 2'h0;

	typedef enum logic [1:0] {
		SRC_INTERNAL_RC = 2'b00,
		SRC_DOG_OSC = 2'b01,
		SRC_MAIN = 2'b10
	} tick_src_type;

	typedef enum logic [0:0] {
		FEED_IDLE = 1'b0,
		FEED_ARMED = 1'b1
	} feed_state_type;
endpackage

// File: src/wdog_prescaler.sv
/*
 * Tick source select and fixed divide-by-four prescaler.
 * Assumes tick inputs are one-cycle enables synchronous to ref_clk_i.
 */
`timescale 1ns/100ps
module wdog_prescaler #(
	parameter bit WINDOWED = 1'b0
) (
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire logic run_i,
	input wire logic [1:0] sel_i,
	input wire logic internal_rc_osc_tick_i,
	input wire logic dedicated_dog_osc_tick_i,
	input wire logic main_tick_i,
	output logic dec_o
);
	logic watchdog_tick_clock;
	logic [1:0] div;

	// Main clock is only offered in the basic variant
	always_comb begin
		case (sel_i)
			wdog_pkg::SRC_INTERNAL_RC: watchdog_tick_clock = internal_rc_osc_tick_i;
			wdog_pkg::SRC_DOG_OSC: watchdog_tick_clock = dedicated_dog_osc_tick_i;
			wdog_pkg::SRC_MAIN: watchdog_tick_clock = WINDOWED ? 1'b0 : main_tick_i;
			default: watchdog_tick_clock = internal_rc_osc_tick_i;
		endcase
	end

	// Divide by four; restarts whenever the timer is stopped
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i || !run_i) begin
			div <= 2'h0;
			dec_o <= 1'b0;
		end else begin
			dec_o <= watchdog_tick_clock && div == wdog_pkg::PRESCALE_LAST;
			if (watchdog_tick_clock)
				div <= div + 2'h1;
		end
	end
endmodule

// File: src/windowed_watchdog_timer.sv
/*
 * Watchdog timer, basic or windowed variant, with feed checking and reset cause.
 * Assumes software access arrives as synchronous one-cycle strobes and that
 * chip_reset_o is folded into the chip reset that drives nrst_i.
 */
// How it works
// - Once enabled, expiry of the counter without a valid reload raises a chip reset.
// - The enable is set by software only and cleared only by reset or a watchdog event.
// - A wrong or broken feed sequence raises a reset or an interrupt as reset-enable says.
// - A flag, kept across the watchdog's own reset, records that it caused the last reset.
// - The counter is 24 bits and steps down through a fixed prescaler from the tick clock.
// - Timeouts run from 256 to 2 to the 24 steps of four tick periods each.
// - The tick clock is chosen among internal RC, watchdog oscillator and, in the basic variant only, main clock.
// - In windowed mode a reload before the window opens counts as an error.
// - In the windowed variant a warning interrupt fires when the count hits a set value.
// - The watchdog reset is one of the chip reset sources beside pin, power-on and brown-out.
`timescale 1ns/100ps
module windowed_watchdog_timer #(
	parameter bit WINDOWED = 1'b1
) (
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire logic por_i,
	input wire logic internal_rc_osc_tick_i,
	input wire logic dedicated_dog_osc_tick_i,
	input wire logic main_tick_i,
	input wire logic enable_set_i,
	input wire logic reset_en_i,
	input wire logic window_mode_i,
	input wire logic warn_en_i,
	input wire logic [1:0] clk_sel_i,
	input wire logic [23:0] timeout_const_i,
	input wire logic [23:0] window_val_i,
	input wire logic [23:0] warn_val_i,
	input wire logic feed_wr_i,
	input wire logic [7:0] feed_data_i,
	input wire logic other_access_i,
	input wire logic flag_clr_i,
	output logic enabled_o,
	output logic [23:0] count_o,
	output logic chip_reset_o,
	output logic wd_irq_o,
	output logic warn_irq_o,
	output logic reset_flag_o
);
	wdog_pkg::feed_state_type feed_state;
	wdog_pkg::feed_state_type next_feed_state;
	logic [23:0] reload_val;
	logic [1:0] sel_q;
	logic dec;
	logic feed_ok;
	logic feed_err;
	logic window_err;
	logic reload;
	logic fault;
	logic expire;

	wdog_prescaler #(
		.WINDOWED(WINDOWED)
	) u_prescaler (
		.ref_clk_i(ref_clk_i),
		.nrst_i(nrst_i),
		.run_i(enabled_o),
		.sel_i(sel_q),
		.internal_rc_osc_tick_i(internal_rc_osc_tick_i),
		.dedicated_dog_osc_tick_i(dedicated_dog_osc_tick_i),
		.main_tick_i(main_tick_i),
		.dec_o(dec)
	);

	// Feed sequence decode: idle cycles may sit between the key pair, any other access or write breaks it
	always_comb begin
		next_feed_state = feed_state;
		feed_ok = 1'b0;
		feed_err = 1'b0;
		case (feed_state)
			wdog_pkg::FEED_IDLE: begin
				if (feed_wr_i && feed_data_i == wdog_pkg::FEED_KEY_FIRST)
					next_feed_state = wdog_pkg::FEED_ARMED;
				else if (feed_wr_i)
					feed_err = 1'b1;
			end
			wdog_pkg::FEED_ARMED: begin
				next_feed_state = wdog_pkg::FEED_IDLE;
				if (feed_wr_i && feed_data_i == wdog_pkg::FEED_KEY_SECOND && !other_access_i)
					feed_ok = 1'b1;
				else if (feed_wr_i || other_access_i)
					feed_err = 1'b1;
				else
					next_feed_state = wdog_pkg::FEED_ARMED;
			end
			default: next_feed_state = wdog_pkg::FEED_IDLE;
		endcase
	end

	// Early reload in windowed mode is a fault, not a feed
	assign window_err = WINDOWED && window_mode_i && feed_ok && count_o > window_val_i;
	assign reload = feed_ok && !window_err;
	assign fault = enabled_o && (feed_err || window_err);
	assign expire = enabled_o && dec && count_o == 24'h000000;
	// Constants below the minimum would give an unusably short period
	assign reload_val = timeout_const_i < wdog_pkg::CONST_MIN ?
		wdog_pkg::CONST_MIN : timeout_const_i;

	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i)
			feed_state <= wdog_pkg::FEED_IDLE;
		else
			feed_state <= next_feed_state;
	end

	// Shadow copies; a change only counts once software feeds again
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			sel_q <= wdog_pkg::SEL_RESET;
		end else if (reload) begin
			sel_q <= clk_sel_i;
		end
	end

	// Sticky enable; software has no way to drop it
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i)
			enabled_o <= 1'b0;
		else if (expire || fault)
			enabled_o <= 1'b0;
		else if (enable_set_i)
			enabled_o <= 1'b1;
	end

	// Down counter, one step per prescaled tick
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i)
			count_o <= wdog_pkg::COUNT_RESET;
		else if (reload)
			count_o <= reload_val;
		else if (enabled_o && dec && count_o != 24'h000000)
			count_o <= count_o - 24'h000001;
	end

	// Consequences: expiry always resets, feed faults follow reset_en_i
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			chip_reset_o <= 1'b0;
			wd_irq_o <= 1'b0;
		end else begin
			chip_reset_o <= expire || (fault && reset_en_i);
			if (fault && !reset_en_i)
				wd_irq_o <= 1'b1;
		end
	end

	// Warning interrupt, sticky until chip reset
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i)
			warn_irq_o <= 1'b0;
		else if (WINDOWED && warn_en_i && enabled_o && count_o == warn_val_i)
			warn_irq_o <= 1'b1;
	end

	// Reset cause survives nrst_i; only power-on or software clears it, set wins
	always_ff @(posedge ref_clk_i) begin
		if (por_i)
			reset_flag_o <= 1'b0;
		else if (chip_reset_o)
			reset_flag_o <= 1'b1;
		else if (flag_clr_i)
			reset_flag_o <= 1'b0;
	end

	sequence key_pair_s;
		feed_wr_i && feed_data_i == wdog_pkg::FEED_KEY_FIRST && feed_state == wdog_pkg::FEED_IDLE
		##1 feed_wr_i && feed_data_i == wdog_pkg::FEED_KEY_SECOND && !other_access_i;
	endsequence

	sequence bad_second_s;
		feed_state == wdog_pkg::FEED_ARMED && other_access_i;
	endsequence

	expire_resets_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		enabled_o && dec && count_o == 24'h000000 |=> chip_reset_o && !enabled_o)
		else $error("expiry did not raise chip reset");

	enable_sticky_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		enabled_o && !fault && !(dec && count_o == 24'h000000) |=> enabled_o)
		else $error("enable dropped without cause");

	fault_reset_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		((enabled_o && reset_en_i) and bad_second_s) |=> chip_reset_o)
		else $error("bad feed gave no reset");

	fault_irq_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		((enabled_o && !reset_en_i) and bad_second_s) |=> wd_irq_o && !chip_reset_o)
		else $error("bad feed gave no interrupt");

	irq_hold_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		wd_irq_o |=> wd_irq_o)
		else $error("fault interrupt dropped");

	enable_set_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		enable_set_i && !expire && !fault |=> enabled_o)
		else $error("enable request ignored");

	cause_flag_a: assert property (@(posedge ref_clk_i) disable iff (por_i)
		chip_reset_o |=> reset_flag_o)
		else $error("reset cause not recorded");

	count_step_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		enabled_o && dec && !reload && count_o != 24'h000000 |=> count_o == $past(count_o) - 24'h000001)
		else $error("counter did not step by one");

	valid_reload_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		key_pair_s ##0 !window_err |=> count_o >= wdog_pkg::CONST_MIN && !chip_reset_o)
		else $error("valid feed did not reload");

	early_feed_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		key_pair_s ##0 (enabled_o && reset_en_i && WINDOWED && window_mode_i
		&& count_o > window_val_i) |=> chip_reset_o)
		else $error("early reload accepted");

	warn_fire_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		WINDOWED && warn_en_i && enabled_o && count_o == warn_val_i |=> warn_irq_o)
		else $error("warning interrupt missing");
endmodule

// File: test/tb_windowed_watchdog_timer.sv
/*
 * Self-checking bench for the watchdog: feeds, ticks, faults, window, warning, expiry.
 * Assumes the design's embedded assertions and a 100 MHz clock; drives ports directly.
 */
`timescale 1ns/100ps
module tb_windowed_watchdog_timer;
	logic ref_clk_i, nrst_i, por_i, rc_t, dog_t, main_t, enable_set_i, reset_en_i;
	logic window_mode_i, warn_en_i, feed_wr_i, other_access_i, flag_clr_i;
	logic enabled_o, chip_reset_o, wd_irq_o, warn_irq_o, reset_flag_o;
	logic [1:0] clk_sel_i;
	logic [7:0] feed_data_i, bad;
	logic [23:0] timeout_const_i, window_val_i, warn_val_i, count_o, c, exp_c;
	logic [23:0] corner [3] = '{24'h000010, 24'h0000FF, 24'hFFFFFF};
	int n_mismatch, checks, n_rst, r0, s, o, k;
	integer seed;

	windowed_watchdog_timer #(.WINDOWED(1'b1)) windowed_watchdog_timer_i (.ref_clk_i(ref_clk_i),
		.nrst_i(nrst_i), .por_i(por_i), .internal_rc_osc_tick_i(rc_t),
		.dedicated_dog_osc_tick_i(dog_t), .main_tick_i(main_t), .enable_set_i(enable_set_i),
		.reset_en_i(reset_en_i), .window_mode_i(window_mode_i), .warn_en_i(warn_en_i),
		.clk_sel_i(clk_sel_i), .timeout_const_i(timeout_const_i), .window_val_i(window_val_i),
		.warn_val_i(warn_val_i), .feed_wr_i(feed_wr_i), .feed_data_i(feed_data_i),
		.other_access_i(other_access_i), .flag_clr_i(flag_clr_i), .enabled_o(enabled_o),
		.count_o(count_o), .chip_reset_o(chip_reset_o), .wd_irq_o(wd_irq_o),
		.warn_irq_o(warn_irq_o), .reset_flag_o(reset_flag_o));

	// Clock
	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end

	// Count reset pulses; a pulse longer than one cycle shows as an extra count
	always @(posedge ref_clk_i) if (chip_reset_o === 1'b1) n_rst++;

	task give_verdict;
		if (n_mismatch == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	// Hang guard
	initial begin
		repeat (100000) @(posedge ref_clk_i);
		n_mismatch++;
		give_verdict;
	end

	task step(input int n);
		repeat (n) begin
			@(posedge ref_clk_i);
			#1;
		end
	endtask

	task cmp(input string what, input logic [23:0] exp, input logic [23:0] got);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	function logic [23:0] clamp(input logic [23:0] v);
		return (v < wdog_pkg::CONST_MIN) ? wdog_pkg::CONST_MIN : v;
	endfunction

	task feed(input logic [7:0] a, input logic [7:0] b);
		feed_wr_i = 1'b1;
		feed_data_i = a;
		step(1);
		feed_data_i = b;
		step(1);
		feed_wr_i = 1'b0;
	endtask

	// Ticks are spaced one idle cycle apart, then the pipeline settles
	task ticks(input int src, input int n);
		repeat (n) begin
			case (src)
				0: rc_t = 1'b1;
				1: dog_t = 1'b1;
				default: main_t = 1'b1;
			endcase
			step(1);
			{rc_t, dog_t, main_t} = 3'h0;
			step(1);
		end
		step(3);
	endtask

	// Reset, enable and give a first valid feed with checking relaxed
	task start(input logic [23:0] v, input logic [1:0] sel);
		{reset_en_i, window_mode_i, warn_en_i, other_access_i} = 4'h0;
		flag_clr_i = 1'b1; // Stale cause flag would hide a missing set later
		nrst_i = 1'b0;
		step(16);
		nrst_i = 1'b1;
		flag_clr_i = 1'b0;
		clk_sel_i = sel;
		timeout_const_i = v;
		enable_set_i = 1'b1;
		step(1);
		enable_set_i = 1'b0;
		feed(wdog_pkg::FEED_KEY_FIRST, wdog_pkg::FEED_KEY_SECOND);
		step(2);
	endtask

	initial begin
		seed = 44;
		{nrst_i, rc_t, dog_t, main_t, enable_set_i, reset_en_i, window_mode_i} = 7'h00;
		{warn_en_i, feed_wr_i, other_access_i, flag_clr_i, clk_sel_i, feed_data_i} = 14'h0000;
		{timeout_const_i, window_val_i, warn_val_i} = 72'h0;
		por_i = 1'b1;
		step(16);
		por_i = 1'b0;
		nrst_i = 1'b1;
		cmp("enabled", 24'h0, enabled_o);
		cmp("count", wdog_pkg::COUNT_RESET, count_o);
		cmp("flag", 24'h0, reset_flag_o);
		// Reload, prescaled decrement, source choice and deferred source change
		for (int i = 0; i < 6; i++) begin
			c = (i < 3) ? corner[i] : 24'($random(seed));
			s = i % 3;
			o = (s == 0) ? 1 : 0;
			k = 1 + ($unsigned($random(seed)) % 3);
			start(c, 2'(s));
			exp_c = clamp(c);
			cmp("count", exp_c, count_o);
			ticks(s, 4 * k);
			exp_c = (s == 2) ? exp_c : exp_c - 24'(k);
			cmp("count", exp_c, count_o);
			clk_sel_i = 2'(o);
			ticks(o, 8);
			cmp("count", exp_c, count_o);
			cmp("enabled", 24'h1, enabled_o);
		end
		// Broken feeds with interrupt consequence, the last one with reset consequence
		for (int i = 0; i < 4; i++) begin
			start(24'h001000, 2'h0);
			bad = 8'($random(seed));
			if (bad == 8'hAA || bad == 8'h55) bad = 8'h3C;
			r0 = n_rst;
			reset_en_i = (i == 3);
			other_access_i = (i >= 2);
			feed((i == 0) ? bad : 8'hAA, (i == 1) ? bad : 8'h55);
			other_access_i = 1'b0;
			step(2);
			cmp("irq", 24'(i < 3), wd_irq_o);
			cmp("enabled", 24'h0, enabled_o);
			cmp("resets", 24'(r0 + (i == 3)), 24'(n_rst));
		end
		// Early feed with reset consequence, then a feed inside the window
		start(24'h000100, 2'h0);
		{reset_en_i, window_mode_i, window_val_i} = {2'h3, 24'h000080};
		r0 = n_rst;
		feed(8'hAA, 8'h55);
		step(2);
		cmp("resets", 24'(r0 + 1), 24'(n_rst));
		cmp("flag", 24'h1, reset_flag_o);
		start(24'h000100, 2'h0);
		{window_mode_i, window_val_i} = {1'b1, 24'h0000FF};
		ticks(0, 4);
		feed(8'hAA, 8'h55);
		step(2);
		cmp("irq", 24'h0, wd_irq_o);
		cmp("count", 24'h000100, count_o);
		// Warning at a set count
		start(24'h000100, 2'h0);
		{warn_en_i, warn_val_i} = {1'b1, 24'h0000FE};
		ticks(0, 4);
		cmp("warn", 24'h0, warn_irq_o);
		ticks(0, 4);
		cmp("warn", 24'h1, warn_irq_o);
		// Expiry at the shortest timeout, flag kept over reset
		start(24'h000010, 2'h0);
		r0 = n_rst;
		ticks(0, 1020);
		cmp("count", 24'h0, count_o);
		cmp("resets", 24'(r0), 24'(n_rst));
		ticks(0, 4);
		cmp("resets", 24'(r0 + 1), 24'(n_rst));
		cmp("enabled", 24'h0, enabled_o);
		nrst_i = 1'b0;
		step(16);
		nrst_i = 1'b1;
		cmp("flag", 24'h1, reset_flag_o);
		flag_clr_i = 1'b1;
		step(1);
		flag_clr_i = 1'b0;
		step(1);
		cmp("flag", 24'h0, reset_flag_o);
		give_verdict;
	end
endmodule
